// ===== lcms_core.sv
// conversion mode control, overrange, ready and above-limit flags
// assumes analog front end signals on the same clock; host on the reg port
//
// Operation
// - mode 00 shutdown, 01 one conversion, 10/11 continuous conversions
// - mode field resets to 00, no conversions until programmed
// - mode reads 01 while a single conversion runs
// - single conversion done clears mode to 00, enters shutdown
// - entering shutdown leaves ready and above flags unchanged
// - flags stay readable with held values throughout shutdown
// - overrange flag bit 8 shows last conversion overflowed, updated each end
// - manual range: transient overload sets overrange despite in-range result
// - auto range: overrange only when top range overflows
// - auto range overflow below top: abort, step range up, restart
// - auto range: overrange updated only when the retry sequence ends
// - ready flag bit 7 set whenever a conversion finishes
// - ready cleared by any control read or non-shutdown write unless a conversion finishes that cycle
// - shutdown write leaves ready flag as it is
// - above flag bit 6 set after fault-count results above high limit
// - overrange, ready and above flags ignore host write data
// - range 1100 is auto and reset value; lower fixed; above reserved
// - fault count codes 00..11 need 1, 2, 4, 8 measurements
// - conversion lasts 100 ms or 800 ms per integration length bit
`timescale 1ns/10ps
`default_nettype none

module lcms_core #(
  parameter int P_SHORT_CYC = lcms_pkg::SHORT_CYC,
  parameter int P_LONG_CYC  = lcms_pkg::LONG_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_adc_overload,
  input  wire logic [11:0] i_adc_mant,
  output logic             o_integrating,
  output logic      [3:0]  o_active_range,
  output logic             o_result_valid,
  output logic      [15:0] o_result
);
  import lcms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  lcms_state_type  state_q,  state_d;
  logic [3:0]      range_q,  range_d;
  logic            ilen_q,   ilen_d;
  logic [1:0]      mode_q,   mode_d;
  logic            ovr_q,    ovr_d;
  logic            rdy_q,    rdy_d;
  logic            above_q,  above_d;
  logic [4:0]      aux_q,    aux_d;
  logic [15:0]     hi_q,     hi_d;
  logic [27:0]     cnt_q,    cnt_d;
  logic            ovl_q,    ovl_d;
  logic [3:0]      arng_q,   arng_d;
  logic [3:0]      fcnt_q,   fcnt_d;
  logic [15:0]     res_q,    res_d;
  logic            resv_q,   resv_d;
  logic [15:0]     rdata_q,  rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  logic            wr_ctrl;
  logic            rd_ctrl;
  logic            auto_sel;
  logic [27:0]     conv_len;
  logic            conv_end;
  logic            ovl_now;
  logic [22:0]     res_val;
  logic [22:0]     hi_val;
  logic [3:0]      fc_need;
  logic [15:0]     ctrl_word;

  assign wr_ctrl  = i_wr && (i_addr == CTRL_OFS);
  assign rd_ctrl  = i_rd && (i_addr == CTRL_OFS);
  assign auto_sel = (range_q == RANGE_AUTO);
  // both lengths fit 28 bits at the core rate
  assign conv_len = ilen_q ? 28'(P_LONG_CYC - 1)
                           : 28'(P_SHORT_CYC - 1);
  assign conv_end = (cnt_q == conv_len);
  assign ovl_now  = ovl_q || i_adc_overload;
  assign res_val  = 23'({11'h000, i_adc_mant} << arng_q);
  assign hi_val   = 23'({11'h000, hi_q[11:0]} << hi_q[15:12]);
  assign fc_need  = 4'(4'h1 << aux_q[FCNT_MSB:0]);

  assign ctrl_word = {range_q, ilen_q, mode_q, ovr_q, rdy_q, above_q,
                      1'b0, aux_q};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    range_d = range_q;
    ilen_d  = ilen_q;
    mode_d  = mode_q;
    ovr_d   = ovr_q;
    rdy_d   = rdy_q;
    above_d = above_q;
    aux_d   = aux_q;
    hi_d    = hi_q;
    cnt_d   = cnt_q;
    ovl_d   = ovl_q;
    arng_d  = arng_q;
    fcnt_d  = fcnt_q;
    res_d   = res_q;
    resv_d  = 1'b0;
    rdata_d = 16'h0000;

    // host reads: answer one cycle later, unmapped reads give zero
    if (rd_ctrl) begin
      rdata_d = ctrl_word;
      rdy_d   = 1'b0;
    end else if (i_rd && (i_addr == HI_LIMIT_OFS)) begin
      rdata_d = hi_q;
    end

    if (i_wr && (i_addr == HI_LIMIT_OFS)) begin
      hi_d = i_wdata;
    end

    // status bits 8:6 are never taken from write data
    if (wr_ctrl) begin
      // reserved range codes are refused, field keeps its value
      if (i_wdata[RANGE_MSB:RANGE_LSB] <= RANGE_AUTO) begin
        range_d = i_wdata[RANGE_MSB:RANGE_LSB];
      end
      ilen_d = i_wdata[ILEN_BIT];
      mode_d = i_wdata[MODE_MSB:MODE_LSB];
      aux_d  = i_wdata[AUX_MSB:0];
      if (i_wdata[MODE_MSB:MODE_LSB] != MODE_OFF) begin
        rdy_d = 1'b0;
      end
    end

    case (state_q)
      ST_IDLE: begin
        // start on the cycle after a non-shutdown mode is present
        if (mode_q != MODE_OFF) begin
          state_d = ST_INTEG;
          cnt_d   = 28'h0000000;
          ovl_d   = 1'b0;
          arng_d  = auto_sel ? RANGE_MIN : range_q;
        end
      end
      ST_INTEG: begin
        cnt_d = cnt_q + 28'h0000001;
        ovl_d = ovl_now;
        if (wr_ctrl && (i_wdata[MODE_MSB:MODE_LSB] == MODE_OFF)) begin
          // host shutdown aborts; flags are left as they are
          state_d = ST_IDLE;
        end else if (auto_sel && i_adc_overload
                     && (arng_q < RANGE_MAX)) begin
          // abort early and retry one range up; no flag touched yet
          arng_d = arng_q + 4'h1;
          cnt_d  = 28'h0000000;
          ovl_d  = 1'b0;
        end else if (conv_end) begin
          ovr_d  = ovl_now;
          rdy_d  = 1'b1;
          res_d  = {arng_q, i_adc_mant};
          resv_d = 1'b1;
          cnt_d  = 28'h0000000;
          ovl_d  = 1'b0;
          if (auto_sel) begin
            arng_d = RANGE_MIN;
          end else begin
            arng_d = range_q;
          end
          // consecutive above-limit measurements, transparent style
          if (res_val > hi_val) begin
            if (fcnt_q + 4'h1 >= fc_need) begin
              above_d = 1'b1;
              fcnt_d  = fc_need;
            end else begin
              fcnt_d  = fcnt_q + 4'h1;
            end
          end else begin
            fcnt_d  = 4'h0;
            above_d = 1'b0;
          end
          if (mode_q == MODE_SINGLE) begin
            // a host write in this cycle keeps its own mode value
            if (!wr_ctrl) begin
              mode_d = MODE_OFF;
            end
            state_d = ST_IDLE;
          end else if (wr_ctrl
                       && (i_wdata[MODE_MSB:MODE_LSB] == MODE_SINGLE)) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      range_q <= RANGE_RST;
      ilen_q  <= ILEN_RST;
      mode_q  <= MODE_OFF;
      ovr_q   <= 1'b0;
      rdy_q   <= 1'b0;
      above_q <= 1'b0;
      aux_q   <= AUX_RST;
      hi_q    <= HI_LIMIT_RST;
      cnt_q   <= 28'h0000000;
      ovl_q   <= 1'b0;
      arng_q  <= RANGE_MIN;
      fcnt_q  <= 4'h0;
      res_q   <= 16'h0000;
      resv_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      range_q <= range_d;
      ilen_q  <= ilen_d;
      mode_q  <= mode_d;
      ovr_q   <= ovr_d;
      rdy_q   <= rdy_d;
      above_q <= above_d;
      aux_q   <= aux_d;
      hi_q    <= hi_d;
      cnt_q   <= cnt_d;
      ovl_q   <= ovl_d;
      arng_q  <= arng_d;
      fcnt_q  <= fcnt_d;
      res_q   <= res_d;
      resv_q  <= resv_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_integrating  = (state_q == ST_INTEG);
  assign o_active_range = arng_q;
  assign o_result_valid = resv_q;
  assign o_result       = res_q;

endmodule : lcms_core

`default_nettype wire

// ===== lcms_pkg.sv
// constants, field layout and timing for the conversion mode and status block
// assumes a single 250 MHz core clock
package lcms_pkg;

  // register offsets on the plain register port
  localparam logic [7:0]  CTRL_OFS       = 8'h01;
  localparam logic [7:0]  HI_LIMIT_OFS   = 8'h03;

  // measurement_control field positions
  localparam int          RANGE_MSB      = 15;
  localparam int          RANGE_LSB      = 12;
  localparam int          ILEN_BIT       = 11;
  localparam int          MODE_MSB       = 10;
  localparam int          MODE_LSB       = 9;
  localparam int          OVR_BIT        = 8;
  localparam int          RDY_BIT        = 7;
  localparam int          ABOVE_BIT      = 6;
  localparam int          BELOW_BIT      = 5;
  localparam int          AUX_MSB        = 4;
  localparam int          FCNT_MSB       = 1;

  // reset values
  localparam logic [3:0]  RANGE_RST      = 4'hc;
  localparam logic        ILEN_RST       = 1'b1;
  localparam logic [4:0]  AUX_RST        = 5'h10;
  localparam logic [15:0] HI_LIMIT_RST   = 16'hbfff;

  // range codes
  localparam logic [3:0]  RANGE_AUTO     = 4'hc;
  localparam logic [3:0]  RANGE_MAX      = 4'hb;
  localparam logic [3:0]  RANGE_MIN      = 4'h0;

  // conversion mode codes
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_SINGLE    = 2'h1;

  // conversion timing
  localparam int          CLK_MHZ        = 250;
  localparam int          T_SHORT_MS     = 100;
  localparam int          T_LONG_MS      = 800;
  localparam int          SHORT_CYC      = T_SHORT_MS * 1000 * CLK_MHZ;
  localparam int          LONG_CYC       = T_LONG_MS * 1000 * CLK_MHZ;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_INTEG = 1'b1
  } lcms_state_type;

endpackage : lcms_pkg

// ===== lcms_core_assertions.sv
// port assertions for the conversion mode and status block
// assumes bind onto lcms_core, one clock, async reset
`timescale 1ns/10ps
`default_nettype none
module lcms_core_chk
  import lcms_pkg::*;
#(
  parameter int P_SHORT_CYC = 20,
  parameter int P_LONG_CYC  = 40
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_adc_overload,
  input wire logic [11:0] i_adc_mant,
  input wire logic        o_integrating,
  input wire logic [3:0]  o_active_range,
  input wire logic        o_result_valid,
  input wire logic [15:0] o_result
);
  logic [3:0]  rng_q, rng_d, prv_q;
  logic        ilen_q, ilen_d, ctl_wr;
  logic [31:0] cnt_q, cnt_d;
  int          len;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of range and length; reserved range codes keep the old value
  always_comb begin
    ctl_wr = i_wr && i_addr == CTRL_OFS;
    rng_d = rng_q;
    ilen_d = ilen_q;
    if (ctl_wr && i_wdata[15:12] <= RANGE_AUTO) rng_d = i_wdata[15:12];
    if (ctl_wr) ilen_d = i_wdata[ILEN_BIT];
    len = ilen_q ? P_LONG_CYC : P_SHORT_CYC;
    cnt_d = cnt_q + 32'h1;
    if (!o_integrating) cnt_d = '0;
    else if (o_result_valid || o_active_range != prv_q) cnt_d = 32'h1;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rng_q <= RANGE_RST;
      ilen_q <= ILEN_RST;
      cnt_q <= '0;
      prv_q <= '0;
    end else begin
      rng_q <= rng_d;
      ilen_q <= ilen_d;
      cnt_q <= cnt_d;
      prv_q <= o_active_range;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_idle_wr;
    ctl_wr && !o_integrating;
  endsequence
  a_single_start: assert property (s_idle_wr ##0
    i_wdata[MODE_MSB:MODE_LSB] == MODE_SINGLE |-> ##2 o_integrating)
    else $error("single shot did not start");
  a_cont_start: assert property (s_idle_wr ##0 i_wdata[MODE_MSB]
    |-> ##2 o_integrating) else $error("continuous did not start");
  a_off_stop: assert property (ctl_wr && i_wdata[10:9] == MODE_OFF
    |-> ##[1:2] !o_integrating) else $error("shutdown write ignored");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_valid_pulse: assert property (o_result_valid |=> !o_result_valid)
    else $error("result valid too long");
  a_result_range: assert property (o_result_valid
    |-> o_result[15:12] == $past(o_active_range)) else $error("bad range");
  a_result_mant: assert property (o_result_valid
    |-> o_result[11:0] == $past(i_adc_mant)) else $error("bad mantissa");
  a_auto_step: assert property (rng_q == RANGE_AUTO && o_integrating
    && i_adc_overload && o_active_range < RANGE_MAX && !i_wr
    |=> o_active_range == $past(o_active_range) + 4'h1)
    else $error("range did not step");
  a_fixed_range: assert property (rng_q < RANGE_AUTO && o_integrating
    |-> o_active_range == rng_q) else $error("fixed range not used");
  a_conv_len: assert property (o_result_valid
    |-> cnt_q == len || cnt_q == len + 1) else $error("bad conversion length");
endmodule : lcms_core_chk
bind lcms_core lcms_core_chk #(.P_SHORT_CYC(P_SHORT_CYC),
  .P_LONG_CYC(P_LONG_CYC)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_adc_overload(i_adc_overload),
  .i_adc_mant(i_adc_mant), .o_integrating(o_integrating),
  .o_active_range(o_active_range), .o_result_valid(o_result_valid),
  .o_result(o_result));
`default_nettype wire

// ===== lcms_fe_model.sv
// front end model: overloads on ranges below a chosen one
// assumes it shares the core clock domain
`timescale 1ns/10ps
`default_nettype none
module lcms_fe_model (
  input  wire logic        i_integrating,
  input  wire logic [3:0]  i_range,
  input  wire logic [3:0]  i_need,
  input  wire logic [11:0] i_mant,
  output logic             o_overload,
  output logic      [11:0] o_mant
);
  // lines misbehave outside integration so a stale sample shows
  assign o_overload = i_integrating ? (i_range < i_need) : 1'b1;
  assign o_mant     = i_integrating ? i_mant : ~i_mant;
endmodule : lcms_fe_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for lcms_core with short conversion counts
// assumes the front end model drives the conversion link
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lcms_pkg::*;
  logic        clk, i_rst, i_wr, i_rd, ovl, integ, vld;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, rdata, res, rv;
  logic [11:0] mant, fmant;
  logic [3:0]  arng, need;
  int          errors, n_checks;
  lcms_core #(.P_SHORT_CYC(20), .P_LONG_CYC(40)) u_dut (.i_core_clk(clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_adc_overload(ovl), .i_adc_mant(fmant),
    .o_integrating(integ), .o_active_range(arng), .o_result_valid(vld),
    .o_result(res));
  lcms_fe_model u_fe (.i_integrating(integ), .i_range(arng), .i_need(need),
    .i_mant(mant), .o_overload(ovl), .o_mant(fmant));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rda(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge clk);
    i_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rda
  task automatic rdc(input logic [15:0] exp);
    rda(CTRL_OFS, exp);
  endtask : rdc
  task automatic wait_vld;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (vld !== 1'b1 && k < 1000);
    chk({15'h0, vld}, 16'h0001);
  endtask : wait_vld
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(16'hc810);
    rda(HI_LIMIT_OFS, 16'hbfff);
    rda(8'h7f, 16'h0000);
    wr(8'h7f, 16'hffff);
    rdc(16'hc810);
    $display("reset test done");
  endtask : t_reset
  task automatic t_single;
    wr(CTRL_OFS, 16'h1210);
    rdc(16'h1210);
    wait_vld();
    wr(CTRL_OFS, 16'h11d0);
    rdc(16'h1090);
    rdc(16'h1010);
    wr(CTRL_OFS, 16'h1210);
    wait_vld();
    wr(CTRL_OFS, 16'h1410);
    rdc(16'h1410);
    wait_vld();
    wait_vld();
    rdc(16'h1490);
    wr(CTRL_OFS, 16'h1010);
    $display("mode test done");
  endtask : t_single
  task automatic t_ovf;
    need <= 4'hf;
    wr(CTRL_OFS, 16'h1210);
    wait_vld();
    rdc(16'h1190);
    wr(CTRL_OFS, 16'hc210);
    wait_vld();
    chk({12'h0, res[15:12]}, 16'h000b);
    rdc(16'hc190);
    need <= 4'h3;
    wr(CTRL_OFS, 16'hc210);
    rdc(16'hc310);
    wait_vld();
    chk({12'h0, res[15:12]}, 16'h0003);
    rdc(16'hc090);
    need <= 4'h0;
    wr(CTRL_OFS, 16'h1a10);
    wait_vld();
    rdc(16'h1890);
    $display("overrange test done");
  endtask : t_ovf
  task automatic t_above;
    wr(HI_LIMIT_OFS, 16'h0010);
    wr(CTRL_OFS, 16'h0411);
    wait_vld();
    rdc(16'h0491);
    wait_vld();
    rdc(16'h04d1);
    wr(CTRL_OFS, 16'h0011);
    repeat (100) @(posedge clk);
    rdc(16'h0051);
    $display("limit test done");
  endtask : t_above
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 26'h0};
    {need, mant, errors, n_checks} = {4'h0, 12'h800, 64'h0};
    repeat (3) @(posedge clk);
    i_rst <= 1'b0;
    t_reset();
    t_single();
    t_ovf();
    t_above();
    complete_run();
  end
endmodule : tb
`default_nettype wire
